// ===== design/stt_timer.sv
// System tick timer: 24-bit down-counter with control, reload, count and calibration registers
//
// Summary of operation
// R1: Count register reads the live 24-bit value; bits 31-24 read zero.
// R2: Any write to the count register clears the counter to zero.
// R3: Clearing the count register by write also clears the reached-zero flag.
// R4: Calibration bit 31 is read-only reference-absent flag, reading zero.
// R5: Calibration bit 30 is read-only inexact flag, zero meaning exactly 10 ms.
// R6: Calibration bits 23-0 read the fixed 10 ms reload constant 0x9C4.
// R7: With the clock source bit clear, counter advances on the oscillator pin clock divided by 32; set, on every bus clock.
// R8: The constant gives 10 ms at 8 MHz; other rates need software reload.
// R9: Setting the enable bit loads the counter from reload and starts it.
// R10: On reaching zero the counter reloads from the reload register.
// R11: Reached-zero flag reads one once per event; reading control clears it.
// R12: With tick interrupt bit set, reaching zero pends the tick exception.
// R13: Enabled counter decrements once per tick; disabled counter holds its value.
`timescale 1ns/100ps
`include "stt_cfg.svh"

module stt_timer #(
    parameter int OSC_DIV = `STT_OSC_DIV
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`STT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   oscillator_input_pin,
    output logic                        tick_pend
);

    localparam int CW = `STT_CNT_W;

    // Reset image of the whole state; reload has no defined value so it starts at zero
    localparam stt_pkg::stt_state_s ST_RST = '{
        bus:     stt_pkg::STT_BUS_IDLE,
        count:   '0,
        reload:  `STT_RELOAD_RST,
        en:      `STT_CTRL_RST,
        tick_interrupt_bit: `STT_CTRL_RST,
        clksrc:  `STT_CTRL_RST,
        flag:    1'b0,
        pend:    1'b0,
        rdata:   '0,
        slverr:  1'b0
    };

    // Calibration word is fixed wiring, never a flop
    localparam logic [31:0] CALIB_WORD = {`STT_NO_REFERENCE_RST, `STT_INEXACT_RST, 6'h00,
                                          `STT_TEN_MS_CONST};

    stt_pkg::stt_state_s st_r;
    stt_pkg::stt_state_s st_nxt;

    logic            ref_tick;
    logic            tick;
    logic            capture;
    logic            done;
    logic            wr_done;
    logic            rd_done;
    logic            hit_ctrl;
    logic            hit_reload;
    logic            hit_count;
    logic            hit_calib;
    logic            zero_set;
    logic            flag_clr;
    logic [31:0]     rd_word;
    logic            rd_miss;

    // Reference tick from the oscillator pin, synchronised inside the divider
    stt_osc_div #(
        .DIV     (OSC_DIV)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .osc_in  (oscillator_input_pin),
        .tick    (ref_tick)
    );

    // Count source: bus clock every cycle, or the divided reference
    assign tick = st_r.clksrc ? 1'b1 : ref_tick;                  // [R7]

    // Address decode
    always_comb begin
        hit_ctrl   = 1'b0;
        hit_reload = 1'b0;
        hit_count  = 1'b0;
        hit_calib  = 1'b0;
        if (paddr == `STT_OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == `STT_OFS_RELOAD) begin
            hit_reload = 1'b1;
        end else if (paddr == `STT_OFS_COUNT) begin
            hit_count = 1'b1;
        end else if (paddr == `STT_OFS_CALIB) begin
            hit_calib = 1'b1;
        end
    end

    // Read multiplexer; unused high bits read as zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_miss = 1'b0;
        if (hit_ctrl) begin
            rd_word[`STT_CTRL_EN_BIT]      = st_r.en;
            rd_word[`STT_CTRL_TICK_INTERRUPT_BIT] = st_r.tick_interrupt_bit;
            rd_word[`STT_CTRL_CLKSRC_BIT]  = st_r.clksrc;
            rd_word[`STT_CTRL_FLAG_BIT]    = st_r.flag;
        end else if (hit_reload) begin
            rd_word = {8'h00, st_r.reload};
        end else if (hit_count) begin
            rd_word = {8'h00, st_r.count};                         // [R1]
        end else if (hit_calib) begin
            rd_word = CALIB_WORD;                                  // [R4] [R5] [R6] [R8]
        end else begin
            rd_miss = 1'b1;
        end
    end

    // Bus phases: data is captured into flops in the setup phase, so reads complete with no wait state
    assign capture = ce && psel && (st_r.bus == stt_pkg::STT_BUS_IDLE);
    assign done    = ce && psel && penable && (st_r.bus == stt_pkg::STT_BUS_HOLD);
    assign wr_done = done && pwrite;
    assign rd_done = done && !pwrite;

    // A status read clears the flag only if the captured word showed it, so a fresh event is never lost
    assign flag_clr = (wr_done && hit_count)                                       // [R3]
                   || (rd_done && hit_ctrl && st_r.rdata[`STT_CTRL_FLAG_BIT]);     // [R11]

    // Reaching zero: the tick that takes the count from one to zero
    assign zero_set = ce && st_r.en && tick && (st_r.count == CW'(1));

    // Next-state logic; everything holds while ce is low
    always_comb begin
        st_nxt = st_r;
        if (ce) begin
            // Bus slave phase and captured answer
            case (st_r.bus)
                stt_pkg::STT_BUS_IDLE: begin
                    if (psel) begin
                        st_nxt.bus    = stt_pkg::STT_BUS_HOLD;
                        st_nxt.rdata  = pwrite ? 32'h00000000 : rd_word;
                        st_nxt.slverr = rd_miss;
                    end
                end
                stt_pkg::STT_BUS_HOLD: begin
                    if (psel && penable) begin
                        st_nxt.bus = stt_pkg::STT_BUS_IDLE;
                    end
                end
                default: begin
                    st_nxt.bus = stt_pkg::STT_BUS_IDLE;
                end
            endcase

            // Counting; a disabled counter simply keeps its value
            if (st_r.en && tick) begin
                if (st_r.count == '0) begin
                    st_nxt.count = st_r.reload;                    // [R10]
                end else begin
                    st_nxt.count = st_r.count - CW'(1);            // [R13]
                end
            end

            // Register writes land only on the completing edge
            if (wr_done) begin
                if (hit_ctrl) begin
                    st_nxt.en      = pwdata[`STT_CTRL_EN_BIT];
                    st_nxt.tick_interrupt_bit = pwdata[`STT_CTRL_TICK_INTERRUPT_BIT];
                    st_nxt.clksrc  = pwdata[`STT_CTRL_CLKSRC_BIT];
                    if (pwdata[`STT_CTRL_EN_BIT] && !st_r.en) begin
                        st_nxt.count = st_r.reload;                // [R9]
                    end
                end else if (hit_reload) begin
                    st_nxt.reload = pwdata[CW-1:0];
                end else if (hit_count) begin
                    st_nxt.count = '0;                             // [R2]
                end
            end

            // Flag: an event in the clearing cycle wins
            if (flag_clr) begin
                st_nxt.flag = 1'b0;
            end
            if (zero_set) begin
                st_nxt.flag = 1'b1;                                // [R11]
            end

            // Pend pulse, only when the tick interrupt bit is set
            st_nxt.pend = zero_set && st_r.tick_interrupt_bit;     // [R12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs: data from flops, handshake combinational
    assign prdata    = st_r.rdata;
    assign pslverr   = st_r.slverr;
    assign pready    = done;
    assign tick_pend = st_r.pend;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Count read returns the value at capture with a zero top byte
    property p_count_read;
        capture && !pwrite && hit_count |=> prdata == {8'h00, $past(st_r.count)};
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong"); // [R1]

    // A count write leaves zero, whatever was written
    property p_count_clear;
        wr_done && hit_count |=> st_r.count == '0;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared"); // [R2]

    // A count write also drops the flag unless a new event arrived
    property p_flag_by_write;
        wr_done && hit_count && !zero_set |=> !st_r.flag;
    endproperty
    a_flag_by_write: assert property (p_flag_by_write) else $error("flag kept on write"); // [R3]

    // Calibration reads: both flags zero and the fixed constant below
    property p_calib_read;
        capture && !pwrite && hit_calib |=> prdata[31:30] == 2'b00
            && prdata[29:24] == 6'h00 && prdata[23:0] == `STT_TEN_MS_CONST;
    endproperty
    a_calib_read: assert property (p_calib_read) else $error("bad calibration"); // [R4] [R5] [R6]

    // Constant matches 10 ms of divided 8 MHz ticks
    property p_calib_basis;
        capture && !pwrite && hit_calib |=> prdata[23:0] == CW'(`STT_TEN_MS_TICKS);
    endproperty
    a_calib_basis: assert property (p_calib_basis) else $error("calibration basis"); // [R8]

    // Enabling a stopped counter loads the reload value
    property p_enable_load;
        wr_done && hit_ctrl && pwdata[`STT_CTRL_EN_BIT] && !st_r.en
            |=> st_r.en && st_r.count == $past(st_r.reload);
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("enable did not load"); // [R9]

    // A tick at zero reloads, unless a write overrides it
    property p_reload_at_zero;
        ce && st_r.en && tick && st_r.count == '0 && !wr_done
            |=> st_r.count == $past(st_r.reload);
    endproperty
    a_reload_at_zero: assert property (p_reload_at_zero) else $error("no reload"); // [R10]

    // Reaching zero sets the flag; a completed status read that saw it clears it
    property p_flag_set;
        zero_set |=> st_r.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // [R11]

    property p_flag_read_clear;
        rd_done && hit_ctrl && st_r.rdata[`STT_CTRL_FLAG_BIT] && !zero_set |=> !st_r.flag;
    endproperty
    a_flag_read_clear: assert property (p_flag_read_clear) else $error("flag stuck"); // [R11]

    // Pend follows reaching zero exactly when the tick interrupt bit is on
    property p_pend;
        ce |=> tick_pend == ($past(zero_set) && $past(st_r.tick_interrupt_bit));
    endproperty
    a_pend: assert property (p_pend) else $error("pend mismatch"); // [R12]

    // Decrement by one per tick while enabled
    property p_decrement;
        ce && st_r.en && tick && st_r.count != '0 && !wr_done
            |=> st_r.count == $past(st_r.count) - CW'(1);
    endproperty
    a_decrement: assert property (p_decrement) else $error("bad decrement"); // [R13]

    // Disabled and untouched for two cycles, the count then stays for the next cycle
    property p_hold;
        !st_r.en && !wr_done ##1 !st_r.en && !wr_done |=> $stable(st_r.count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while disabled"); // [R13]

    // Enabled but between ticks, an untouched count stays put
    property p_wait_tick;
        ce && st_r.en && !tick && !wr_done |=> $stable(st_r.count);
    endproperty
    a_wait_tick: assert property (p_wait_tick) else $error("count moved off tick"); // [R13]

    // With the tick interrupt bit off, reaching zero pends nothing
    property p_no_pend;
        ce && !st_r.tick_interrupt_bit |=> !tick_pend;
    endproperty
    a_no_pend: assert property (p_no_pend) else $error("pend with bit off"); // [R12]

    // Clock enable low freezes every register of the core, bus phase included
    property p_freeze;
        !ce |=> $stable(st_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");

endmodule : stt_timer

// ===== design/stt_cfg.svh
// Constants for the system tick timer: offsets, bit positions, reset values and counts
`ifndef STT_CFG_SVH
`define STT_CFG_SVH

// Register byte offsets on the peripheral bus
`define STT_ADDR_W            12
`define STT_OFS_CTRL          12'h010
`define STT_OFS_RELOAD        12'h014
`define STT_OFS_COUNT         12'h018
`define STT_OFS_CALIB         12'h01C

// Counter width and control/status field positions
`define STT_CNT_W             24
`define STT_CTRL_EN_BIT       0
`define STT_CTRL_TICK_INTERRUPT_BIT 1
`define STT_CTRL_CLKSRC_BIT   2
`define STT_CTRL_FLAG_BIT     16

// Calibration register fields and their fixed values
`define STT_CAL_NO_REFERENCE_BIT 31
`define STT_CAL_INEXACT_BIT   30
`define STT_NO_REFERENCE_RST  1'b0
`define STT_INEXACT_RST       1'b0
`define STT_TEN_MS_CONST      24'h0009C4

// Reset values of software-written fields
`define STT_RELOAD_RST        24'h000000
`define STT_CTRL_RST          1'b0

// Oscillator divider and the calibration basis
`define STT_OSC_DIV           32
`define STT_DIV_W             5
`define STT_OSC_FREQ_KHZ      8000
`define STT_CAL_PERIOD_MS     10
`define STT_TEN_MS_TICKS      ((`STT_OSC_FREQ_KHZ * `STT_CAL_PERIOD_MS) / `STT_OSC_DIV)

`endif

// ===== design/stt_pkg.sv
// Types shared by the system tick timer modules
`include "stt_cfg.svh"

package stt_pkg;

    // Bus slave phase, one-hot
    typedef enum logic [1:0] {
        STT_BUS_IDLE = 2'b01,
        STT_BUS_HOLD = 2'b10
    } stt_bus_e;

    // Whole state of the timer core
    typedef struct packed {
        stt_bus_e                  bus;
        logic [`STT_CNT_W-1:0]     count;
        logic [`STT_CNT_W-1:0]     reload;
        logic                      en;
        logic                      tick_interrupt_bit;
        logic                      clksrc;
        logic                      flag;
        logic                      pend;
        logic [31:0]               rdata;
        logic                      slverr;
    } stt_state_s;

    // Whole state of the oscillator divider
    typedef struct packed {
        logic                      s1;
        logic                      s2;
        logic                      prev;
        logic [`STT_DIV_W-1:0]     cnt;
        logic                      tick;
    } stt_div_s;

endpackage : stt_pkg

// ===== design/stt_osc_div.sv
// Oscillator pin synchroniser and divide-by-N tick generator
`timescale 1ns/100ps
`include "stt_cfg.svh"

module stt_osc_div #(
    parameter int DIV = `STT_OSC_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic osc_in,
    output logic      tick
);

    localparam logic [`STT_DIV_W-1:0] LAST = `STT_DIV_W'(DIV - 1);

    stt_pkg::stt_div_s st_r;
    stt_pkg::stt_div_s st_nxt;
    logic              rise;

    // Edge seen only after both synchroniser stages; s1 feeds s2 alone
    assign rise = st_r.s2 & ~st_r.prev;
    assign tick = st_r.tick;

    // One tick per DIV rising oscillator edges
    always_comb begin
        st_nxt = st_r;
        if (ce) begin
            st_nxt.s1   = osc_in;
            st_nxt.s2   = st_r.s1;
            st_nxt.prev = st_r.s2;
            st_nxt.tick = 1'b0;
            if (rise) begin
                if (st_r.cnt == LAST) begin                      // [R7]
                    st_nxt.cnt  = '0;
                    st_nxt.tick = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + `STT_DIV_W'(1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The last edge of a group gives a tick on the next cycle
    property p_div_tick;
        ce && rise && st_r.cnt == LAST |=> tick && st_r.cnt == '0;
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("divider missed its tick"); // [R7]

    // No tick without the closing edge of a group
    property p_div_quiet;
        ce && !(rise && st_r.cnt == LAST) |=> !tick;
    endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("divider ticked early"); // [R7]

endmodule : stt_osc_div

// ===== tb/system_tick_timer_regs_test.sv
// Self-checking bench for the system tick timer register block
`timescale 1ns/100ps
`include "stt_cfg.svh"

module system_tick_timer_regs_test;

    // Short divider so an oscillator-driven period takes tens of cycles, not hundreds
    localparam int DIV = 4;

    logic                   pclk;
    logic                   presetn;
    logic                   ce;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`STT_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   osc;
    logic                   tick_pend;
    logic [1:0]             osc_cnt;
    logic [31:0]            rd;
    logic [31:0]            c1;
    logic                   err;
    int                     num_errors;
    int                     compares;
    int                     cycles;
    int                     gap;

    stt_timer #(.OSC_DIV(DIV)) dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .ce                   (ce),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .oscillator_input_pin (osc),
        .tick_pend            (tick_pend)
    );

    // Bus clock, 40 ns period
    always #20 pclk = ~pclk;

    // Oscillator at a quarter of the bus clock, well under the pclk/2 limit
    always @(posedge pclk) begin
        osc_cnt <= osc_cnt + 2'd1;
        osc     <= osc_cnt[1];
    end

    // Cycle ceiling cuts a hung run short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One bus transfer: setup, then access held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        check(n, rd, e);
        check({n, "_err"}, {31'h0, err}, 32'h00000000);
    endtask : rchk

    // Counts edges up to the next tick pulse; gives up after 200
    task automatic wait_pend(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tick_pend !== 1'b1 && n < 200);
    endtask : wait_pend

    // Main sequence
    initial begin
        pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; osc = 0; osc_cnt = 0;
        num_errors = 0; compares = 0; cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl_rst", `STT_OFS_CTRL, 32'h00000000);
        rchk("count_rst", `STT_OFS_COUNT, 32'h00000000);
        rchk("reload_rst", `STT_OFS_RELOAD, 32'h00000000);
        rchk("calib", `STT_OFS_CALIB, 32'h000009C4);
        check("calib_basis", rd & 32'h00FFFFFF, 32'(8000 * 10 / 32));
        // Calibration is read-only; a write neither errors nor changes it
        xfer(1'b1, `STT_OFS_CALIB, 32'hFFFFFFFF);
        check("calib_wr_err", {31'h0, err}, 32'h00000000);
        rchk("calib_after_wr", `STT_OFS_CALIB, 32'h000009C4);
        // Unmapped places answer with an error and zero data
        xfer(1'b0, 12'h020, 32'h00000000);
        check("unmapped_rd_err", {31'h0, err}, 32'h00000001);
        check("unmapped_rd_data", rd, 32'h00000000);
        xfer(1'b1, 12'h000, 32'h12345678);
        check("unmapped_wr_err", {31'h0, err}, 32'h00000001);
        xfer(1'b1, `STT_OFS_RELOAD, 32'hFFFFFFFF);
        rchk("reload_width", `STT_OFS_RELOAD, 32'h00FFFFFF);
        // Free-running at one decrement per bus clock; captures sit 3 edges apart
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000005);
        repeat (5) @(posedge pclk);
        xfer(1'b0, `STT_OFS_COUNT, 32'h00000000);
        c1 = rd;
        check("count_upper", {24'h0, c1[31:24]}, 32'h00000000);
        xfer(1'b0, `STT_OFS_COUNT, 32'h00000000);
        check("count_step", c1 - rd, 32'h00000003);
        // Clock enable low for 10 edges: only 4 of the 14 edges up to the next capture count
        c1 = rd;
        @(posedge pclk);
        ce <= 1'b0;
        repeat (10) @(posedge pclk);
        ce <= 1'b1;
        xfer(1'b0, `STT_OFS_COUNT, 32'h00000000);
        check("count_freeze", c1 - rd, 32'h00000004);
        // Disabled counter holds
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000004);
        xfer(1'b0, `STT_OFS_COUNT, 32'h00000000);
        c1 = rd;
        xfer(1'b0, `STT_OFS_COUNT, 32'h00000000);
        check("count_hold", rd, c1);
        // Any written value clears the count
        xfer(1'b1, `STT_OFS_COUNT, 32'h00123456);
        rchk("count_clear", `STT_OFS_COUNT, 32'h00000000);
        // Enable from a zero count must start from the reload, not wrap first
        xfer(1'b1, `STT_OFS_RELOAD, 32'h00000005);
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000007);
        wait_pend(gap);
        check("first_pend", gap, 32'd6);
        wait_pend(gap);
        check("pend_period", gap, 32'd6);
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000004);
        rchk("flag_set", `STT_OFS_CTRL, 32'h00010004);
        rchk("flag_cleared", `STT_OFS_CTRL, 32'h00000004);
        // Without the tick interrupt bit nothing pends, yet the flag still sets
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000005);
        wait_pend(gap);
        check("no_pend", gap, 32'd200);
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000004);
        rchk("flag_no_int", `STT_OFS_CTRL, 32'h00010004);
        // Set the flag again, then let a count write clear it
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000005);
        repeat (8) @(posedge pclk);
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000004);
        xfer(1'b1, `STT_OFS_COUNT, 32'h00000000);
        rchk("flag_by_count_wr", `STT_OFS_CTRL, 32'h00000004);
        // Divided oscillator: one tick per DIV rising edges, an edge every 4 bus clocks
        xfer(1'b1, `STT_OFS_RELOAD, 32'h00000002);
        xfer(1'b1, `STT_OFS_CTRL, 32'h00000003);
        wait_pend(gap);
        wait_pend(gap);
        check("osc_period", gap, 32'(3 * DIV * 4));
        // Second reset in mid-run returns registers to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl_rst2", `STT_OFS_CTRL, 32'h00000000);
        rchk("reload_rst2", `STT_OFS_RELOAD, 32'h00000000);
        rchk("count_rst2", `STT_OFS_COUNT, 32'h00000000);
        stop_test();
    end

endmodule : system_tick_timer_regs_test
